// file: verif/tb.sv
`timescale 1ns/1ps

module tb;
  logic                   clk = 1'b0;
  logic                   rst_b = 1'b0;
  logic [7:0]             addr = 8'h00;
  logic [7:0]             wdata = 8'h00;
  logic                   wr = 1'b0;
  logic                   rd = 1'b0;
  logic                   bit_wr = 1'b0;
  logic                   bit_val = 1'b0;
  logic [7:0]             rdata;
  cpu_flags_pkg::alu_op_e op = cpu_flags_pkg::OP_NOP;
  logic [7:0]             operand = 8'h00;
  logic [7:0]             acc;
  logic [7:0]             program_status_word;
  logic [7:0]             op_hi;
  logic [2:0]             reg_idx = 3'h0;
  logic [7:0]             reg_addr;
  int                     n_mismatch = 0;
  int                     check_count = 0;

  // byte addresses of the accumulator and the status word
  localparam logic [7:0] ACC_AT = 8'hE0;
  localparam logic [7:0] SW_AT  = 8'hD0;

  always #2 clk = ~clk;

  cpu_status_flags_and_accumulator i_cpu_status_flags_and_accumulator (
    .I_CLOCK    (clk),
    .I_RST_B    (rst_b),
    .I_ADDR     (addr),
    .I_WDATA    (wdata),
    .I_WR       (wr),
    .I_RD       (rd),
    .I_BIT_WR   (bit_wr),
    .I_BIT_VAL  (bit_val),
    .O_RDATA    (rdata),
    .I_OP       (op),
    .I_OPERAND  (operand),
    .O_ACC      (acc),
    .O_PSW      (program_status_word),
    .O_OP_HI    (op_hi),
    .I_REG_IDX  (reg_idx),
    .O_REG_ADDR (reg_addr)
  );

  task automatic chk(input string name, input logic [7:0] seen,
                     input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk("rdata", rdata, exp);
  endtask

  task automatic bit_write(input logic [7:0] a, input logic v);
    @(posedge clk);
    bit_wr  <= 1'b1;
    bit_val <= v;
    addr    <= a;
    @(posedge clk);
    bit_wr  <= 1'b0;
    #1;
  endtask

  task automatic arith(input logic [7:0] a, input cpu_flags_pkg::alu_op_e o,
                       input logic [7:0] b, input logic [7:0] exp_acc,
                       input logic [7:0] exp_sw);
    wr_reg(ACC_AT, a);
    @(posedge clk);
    op      <= o;
    operand <= b;
    @(posedge clk);
    op      <= cpu_flags_pkg::OP_NOP;
    #1;
    chk("acc", acc, exp_acc);
    chk("psw", program_status_word, exp_sw);
  endtask

  task automatic t_reset_and_regs;
    chk("acc_rst", acc, 8'h00);
    chk("psw_rst", program_status_word, 8'h00);
    chk("hi_rst", op_hi, 8'h00);
    rd_reg(ACC_AT, 8'h00);
    rd_reg(8'h55, 8'h00);
    wr_reg(8'h55, 8'hFF);
    wr_reg(ACC_AT, 8'hA5);
    rd_reg(ACC_AT, 8'hA5);
    wr_reg(SW_AT, 8'hFF);
    chk("psw_b0", program_status_word, 8'hFE);
  endtask

  task automatic t_add_sub;
    wr_reg(SW_AT, 8'h00);
    arith(8'hFF, cpu_flags_pkg::OP_ADD, 8'h01, 8'h00, 8'hC0);
    arith(8'h00, cpu_flags_pkg::OP_ADD, 8'h01, 8'h01, 8'h00);
    arith(8'h7F, cpu_flags_pkg::OP_ADD, 8'h01, 8'h80, 8'h44);
    arith(8'h00, cpu_flags_pkg::OP_SUBB, 8'h01, 8'hFF, 8'hC0);
    arith(8'h10, cpu_flags_pkg::OP_ADDC, 8'h20, 8'h31, 8'h00);
    arith(8'h80, cpu_flags_pkg::OP_SUBB, 8'h01, 8'h7F, 8'h44);
  endtask

  task automatic t_mul_div;
    wr_reg(SW_AT, 8'h80);
    arith(8'h10, cpu_flags_pkg::OP_MUL, 8'h20, 8'h00, 8'h04);
    chk("hi", op_hi, 8'h02);
    arith(8'h07, cpu_flags_pkg::OP_DIV, 8'h00, 8'h07, 8'h04);
    chk("hi", op_hi, 8'h02);
    arith(8'h07, cpu_flags_pkg::OP_DIV, 8'h02, 8'h03, 8'h00);
    chk("hi", op_hi, 8'h01);
    arith(8'h02, cpu_flags_pkg::OP_MUL, 8'h03, 8'h06, 8'h00);
    chk("hi", op_hi, 8'h00);
  endtask

  task automatic t_banks;
    for (int b = 0; b < 4; b++) begin
      wr_reg(SW_AT, 8'(b << 3));
      for (int i = 0; i < 8; i += 7) begin
        @(posedge clk);
        reg_idx <= 3'(i);
        @(posedge clk);
        #1;
        chk("reg_addr", reg_addr, 8'(b * 8 + i));
      end
    end
  endtask

  // user flags must ride through arithmetic untouched
  task automatic t_user_flags;
    wr_reg(SW_AT, 8'h22);
    arith(8'hFF, cpu_flags_pkg::OP_ADD, 8'h01, 8'h00, 8'hE2);
    bit_write(SW_AT + 8'h05, 1'b0);
    chk("psw_user0", program_status_word, 8'hC2);
    bit_write(SW_AT + 8'h01, 1'b0);
    bit_write(SW_AT + 8'h05, 1'b1);
    chk("psw_user1", program_status_word, 8'hE0);
    rd_reg(SW_AT, 8'hE0);
  endtask

  // software write and carry in one cycle: the hardware flags win
  task automatic t_set_wins;
    wr_reg(ACC_AT, 8'hFF);
    wr_reg(SW_AT, 8'h00);
    @(posedge clk);
    op      <= cpu_flags_pkg::OP_ADD;
    operand <= 8'h01;
    wr      <= 1'b1;
    addr    <= SW_AT;
    wdata   <= 8'h22;
    @(posedge clk);
    op      <= cpu_flags_pkg::OP_NOP;
    wr      <= 1'b0;
    #1;
    chk("race_psw", program_status_word, 8'hE2);
    chk("race_acc", acc, 8'h00);
    bit_write(ACC_AT + 8'h03, 1'b1);
    chk("acc_bit3", acc, 8'h08);
    bit_write(ACC_AT + 8'h07, 1'b1);
    chk("acc_bit7", acc, 8'h88);
    rd_reg(ACC_AT, 8'h88);
  endtask

  initial begin
    #20000;
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_reset_and_regs();
    t_add_sub();
    t_mul_div();
    t_banks();
    t_user_flags();
    t_set_wins();
    tally_and_finish();
  end
endmodule

// file: verilog/cpu_flags_defines.svh
`ifndef CPU_FLAGS_DEFINES_SVH
`define CPU_FLAGS_DEFINES_SVH

// register offsets in the special register space
`define ACC_OFFSET    8'hE0
`define PSW_OFFSET    8'hD0

// reset values
`define ACC_RESET     8'h00
`define PSW_RESET     8'h00
`define HI_RESET      8'h00

// status word field positions
`define BIT_CARRY     7
`define BIT_HALF      6
`define BIT_USER0     5
`define BIT_BANK_HI   4
`define BIT_BANK_LO   3
`define BIT_OVFL      2
`define BIT_USER1     1

// bit 0 of the status word is not held here and reads as zero
`define PSW_WMASK     8'hFE

// bit access: upper five address bits pick the byte, lower three the bit
`define BIT_REG_MASK  8'hF8

// working-register bank geometry
`define BANK_BYTES    8'h08

`endif

// file: verilog/cpu_flags_pkg.sv
package cpu_flags_pkg;

  typedef enum logic [2:0] {
    OP_NOP,
    OP_ADD,
    OP_ADDC,
    OP_SUBB,
    OP_MUL,
    OP_DIV
  } alu_op_e;

  typedef logic [1:0] bank_t;
  typedef logic [7:0] byte_t;

endpackage

// file: verilog/cpu_status_flags_and_accumulator.sv
// Behaviour
// - carry flag set on carry or borrow
// - carry and half carry cleared otherwise by add and subtract; multiply and divide clear carry only
// - half carry set on nibble carry or borrow
// - banks 0, 1, 2, 3 map to fixed ranges
// - overflow set on sign, product, zero divisor
// - overflow cleared when arithmetic has no overflow
// - two user flags only software changes
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "cpu_flags_defines.svh"

module cpu_status_flags_and_accumulator (
  // clock and reset
  input  wire logic                   I_CLOCK,
  input  wire logic                   I_RST_B,
  // register port
  input  wire logic [7:0]             I_ADDR,
  input  wire logic [7:0]             I_WDATA,
  input  wire logic                   I_WR,
  input  wire logic                   I_RD,
  input  wire logic                   I_BIT_WR,
  input  wire logic                   I_BIT_VAL,
  output logic      [7:0]             O_RDATA,
  // execution port
  input  wire cpu_flags_pkg::alu_op_e I_OP,
  input  wire logic [7:0]             I_OPERAND,
  output logic      [7:0]             O_ACC,
  output logic      [7:0]             O_PSW,
  output logic      [7:0]             O_OP_HI,
  // working-register mapping
  input  wire logic [2:0]             I_REG_IDX,
  output logic      [7:0]             O_REG_ADDR
);

  function automatic logic [7:0] bank_addr(
    input logic [1:0] bank,
    input logic [2:0] idx
  );
    bank_addr = {3'b000, bank, idx};
  endfunction

  logic [7:0] acc_r;
  logic [7:0] acc_nxt;
  logic [7:0] psw_r;
  logic [7:0] psw_nxt;
  logic [7:0] hi_r;
  logic [7:0] hi_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] reg_addr_r;
  logic [7:0] reg_addr_nxt;

  logic [7:0] alu_res;
  logic [7:0] alu_hi;
  logic       alu_carry;
  logic       alu_half;
  logic       alu_ovfl;
  logic       alu_wr_res;
  logic       alu_wr_hi;
  logic       upd_carry;
  logic       upd_half;
  logic       upd_ovfl;
  logic [1:0] bank;

  assign bank = psw_r[`BIT_BANK_HI:`BIT_BANK_LO];

  flag_alu u_alu (
    .i_op        (I_OP),
    .i_a         (acc_r),
    .i_b         (I_OPERAND),
    .i_cin       (psw_r[`BIT_CARRY]),
    .o_res       (alu_res),
    .o_hi        (alu_hi),
    .o_carry     (alu_carry),
    .o_half      (alu_half),
    .o_ovfl      (alu_ovfl),
    .o_wr_res    (alu_wr_res),
    .o_wr_hi     (alu_wr_hi),
    .o_upd_carry (upd_carry),
    .o_upd_half  (upd_half),
    .o_upd_ovfl  (upd_ovfl)
  );

  always_comb begin
    acc_nxt      = acc_r;
    psw_nxt      = psw_r;
    hi_nxt       = hi_r;
    rdata_nxt    = 8'h00;
    reg_addr_nxt = bank_addr(bank, I_REG_IDX);
    // reads see the value held before this cycle's updates
    if (I_RD) begin
      if (I_ADDR == `ACC_OFFSET) begin
        rdata_nxt = acc_r;
      end else if (I_ADDR == `PSW_OFFSET) begin
        rdata_nxt = psw_r;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
    if (I_WR) begin
      if (I_ADDR == `ACC_OFFSET) begin
        acc_nxt = I_WDATA;
      end else if (I_ADDR == `PSW_OFFSET) begin
        psw_nxt = I_WDATA & `PSW_WMASK;
      end
    end else if (I_BIT_WR) begin
      if ((I_ADDR & `BIT_REG_MASK) == `ACC_OFFSET) begin
        acc_nxt[I_ADDR[2:0]] = I_BIT_VAL;
      end else if ((I_ADDR & `BIT_REG_MASK) == `PSW_OFFSET) begin
        psw_nxt[I_ADDR[2:0]] = I_BIT_VAL;
        psw_nxt              = psw_nxt & `PSW_WMASK;
      end
    end
    // hardware results land after software so a flag set by an
    // instruction in the same cycle as a software clear is not lost
    if (alu_wr_res) begin
      acc_nxt = alu_res;
    end
    if (alu_wr_hi) begin
      hi_nxt = alu_hi;
    end
    if (upd_carry) begin
      psw_nxt[`BIT_CARRY] = alu_carry;
    end
    if (upd_half) begin
      psw_nxt[`BIT_HALF] = alu_half;
    end
    if (upd_ovfl) begin
      psw_nxt[`BIT_OVFL] = alu_ovfl;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      acc_r      <= `ACC_RESET;
      psw_r      <= `PSW_RESET;
      hi_r       <= `HI_RESET;
      rdata_r    <= 8'h00;
      reg_addr_r <= 8'h00;
    end else begin
      acc_r      <= acc_nxt;
      psw_r      <= psw_nxt;
      hi_r       <= hi_nxt;
      rdata_r    <= rdata_nxt;
      reg_addr_r <= reg_addr_nxt;
    end
  end

  assign O_ACC      = acc_r;
  assign O_PSW      = psw_r;
  assign O_OP_HI    = hi_r;
  assign O_RDATA    = rdata_r;
  assign O_REG_ADDR = reg_addr_r;

  // checks

  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_B);

  logic [8:0]  chk_sum9;
  logic [4:0]  chk_nib5;
  logic [15:0] chk_prod;
  logic [8:0]  chk_diff9;
  logic        chk_add_ov;
  assign chk_sum9   = {1'b0, acc_r} + {1'b0, I_OPERAND};
  assign chk_nib5   = {1'b0, acc_r[3:0]} + {1'b0, I_OPERAND[3:0]};
  assign chk_prod   = {8'h00, acc_r} * {8'h00, I_OPERAND};
  assign chk_diff9  = {1'b0, acc_r} - {1'b0, I_OPERAND} -
                      {8'h00, psw_r[`BIT_CARRY]};
  assign chk_add_ov = (acc_r[7] == I_OPERAND[7]) &&
                      (chk_sum9[7] != acc_r[7]);

  property p_carry_set;
    (I_OP == cpu_flags_pkg::OP_ADD && chk_sum9[8]) ||
    (I_OP == cpu_flags_pkg::OP_SUBB && !psw_r[`BIT_CARRY] &&
     (acc_r < I_OPERAND))
    |=> O_PSW[`BIT_CARRY] ##1 (O_PSW[`BIT_CARRY] || $past(I_OP) !=
                               cpu_flags_pkg::OP_NOP || $past(I_WR) ||
                               $past(I_BIT_WR));
  endproperty
  a_carry_set: assert property (p_carry_set)
    else $error("carry flag not set after carry or borrow");

  property p_no_carry_clears;
    I_OP == cpu_flags_pkg::OP_ADD && !chk_sum9[8] && !chk_nib5[4]
    |=> !O_PSW[`BIT_CARRY] && !O_PSW[`BIT_HALF];
  endproperty
  a_no_carry_clears: assert property (p_no_carry_clears)
    else $error("carry or half carry left set without a carry");

  property p_sub_borrow;
    I_OP == cpu_flags_pkg::OP_SUBB && chk_diff9[8]
    |=> O_PSW[`BIT_CARRY] && O_ACC == $past(chk_diff9[7:0]);
  endproperty
  a_sub_borrow: assert property (p_sub_borrow)
    else $error("borrow did not set the carry flag");

  property p_sub_no_borrow;
    I_OP == cpu_flags_pkg::OP_SUBB && !chk_diff9[8]
    |=> !O_PSW[`BIT_CARRY];
  endproperty
  a_sub_no_borrow: assert property (p_sub_no_borrow)
    else $error("carry flag left set without a borrow");

  // multiply and divide never leave a carry behind
  property p_muldiv_carry_clear;
    I_OP == cpu_flags_pkg::OP_MUL || I_OP == cpu_flags_pkg::OP_DIV
    |=> !O_PSW[`BIT_CARRY];
  endproperty
  a_muldiv_carry_clear: assert property (p_muldiv_carry_clear)
    else $error("carry flag set after multiply or divide");

  property p_muldiv_half_keep;
    (I_OP == cpu_flags_pkg::OP_MUL || I_OP == cpu_flags_pkg::OP_DIV) &&
    !I_WR && !I_BIT_WR
    |=> O_PSW[`BIT_HALF] == $past(psw_r[`BIT_HALF]);
  endproperty
  a_muldiv_half_keep: assert property (p_muldiv_half_keep)
    else $error("half carry changed by multiply or divide");

  property p_half_carry;
    I_OP == cpu_flags_pkg::OP_ADD && chk_nib5[4]
    |=> O_PSW[`BIT_HALF] && O_ACC == $past(chk_sum9[7:0]);
  endproperty
  a_half_carry: assert property (p_half_carry)
    else $error("half carry not set after nibble carry");

  property p_bank_fixed;
    bank != 2'b01
    |=> O_REG_ADDR == ($past(bank) == 2'b00 ? 8'h00 :
                       $past(bank) == 2'b10 ? 8'h10 : 8'h18) +
                      {5'b00000, $past(I_REG_IDX)};
  endproperty
  a_bank_fixed: assert property (p_bank_fixed)
    else $error("working register address wrong for bank");

  property p_bank_one;
    bank == 2'b01 |=> O_REG_ADDR == `BANK_BYTES +
                      {5'b00000, $past(I_REG_IDX)};
  endproperty
  a_bank_one: assert property (p_bank_one)
    else $error("bank one does not map to 0x08 range");

  property p_ov_set;
    (I_OP == cpu_flags_pkg::OP_DIV && I_OPERAND == 8'h00) ||
    (I_OP == cpu_flags_pkg::OP_MUL && |chk_prod[15:8])
    |=> O_PSW[`BIT_OVFL] && !O_PSW[`BIT_CARRY];
  endproperty
  a_ov_set: assert property (p_ov_set)
    else $error("overflow flag not set");

  property p_add_sign_ov;
    I_OP == cpu_flags_pkg::OP_ADD && chk_add_ov |=> O_PSW[`BIT_OVFL];
  endproperty
  a_add_sign_ov: assert property (p_add_sign_ov)
    else $error("signed overflow of an add not flagged");

  property p_add_no_ov;
    I_OP == cpu_flags_pkg::OP_ADD && !chk_add_ov |=> !O_PSW[`BIT_OVFL];
  endproperty
  a_add_no_ov: assert property (p_add_no_ov)
    else $error("overflow flag left set after a clean add");

  // a zero divisor must leave both result registers alone
  property p_div_zero_keep;
    I_OP == cpu_flags_pkg::OP_DIV && I_OPERAND == 8'h00
    |=> O_ACC == $past(acc_r) && $stable(O_OP_HI);
  endproperty
  a_div_zero_keep: assert property (p_div_zero_keep)
    else $error("divide by zero changed a result register");

  property p_ov_clear;
    (I_OP == cpu_flags_pkg::OP_MUL && ~|chk_prod[15:8]) ||
    (I_OP == cpu_flags_pkg::OP_DIV && I_OPERAND != 8'h00)
    |=> !O_PSW[`BIT_OVFL] &&
        O_OP_HI == $past(I_OP == cpu_flags_pkg::OP_MUL ?
                         chk_prod[15:8] : acc_r % I_OPERAND);
  endproperty
  a_ov_clear: assert property (p_ov_clear)
    else $error("overflow flag not cleared");

  property p_user_flags_hold;
    !I_WR && !I_BIT_WR
    |=> $stable(O_PSW[`BIT_USER0]) && $stable(O_PSW[`BIT_USER1]);
  endproperty
  a_user_flags_hold: assert property (p_user_flags_hold)
    else $error("user flag changed without a software write");

  property p_user_flags_write;
    I_WR && I_ADDR == `PSW_OFFSET
    |=> O_PSW[`BIT_USER0] == $past(I_WDATA[`BIT_USER0]) &&
        O_PSW[`BIT_USER1] == $past(I_WDATA[`BIT_USER1]);
  endproperty
  a_user_flags_write: assert property (p_user_flags_write)
    else $error("user flag write not stored");

  property p_user_flag_bit;
    I_BIT_WR && !I_WR && (I_ADDR & `BIT_REG_MASK) == `PSW_OFFSET &&
    I_ADDR[2:0] == 3'(`BIT_USER0)
    |=> O_PSW[`BIT_USER0] == $past(I_BIT_VAL);
  endproperty
  a_user_flag_bit: assert property (p_user_flag_bit)
    else $error("user flag bit write not stored");

  // an instruction flag beats a software clear in the same cycle
  property p_set_wins;
    I_OP == cpu_flags_pkg::OP_ADD && chk_sum9[8] && I_WR &&
    I_ADDR == `PSW_OFFSET
    |=> O_PSW[`BIT_CARRY];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("software write cleared a carry set by hardware");

  property p_bit_acc;
    I_BIT_WR && !I_WR && I_OP == cpu_flags_pkg::OP_NOP &&
    (I_ADDR & `BIT_REG_MASK) == `ACC_OFFSET
    |=> O_ACC[$past(I_ADDR[2:0])] == $past(I_BIT_VAL);
  endproperty
  a_bit_acc: assert property (p_bit_acc)
    else $error("bit write to operand register not stored");

  property p_low_bit_zero;
    !O_PSW[0];
  endproperty
  a_low_bit_zero: assert property (p_low_bit_zero)
    else $error("unused status bit is not zero");

  property p_rdata_idle;
    !I_RD |=> O_RDATA == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data present without a read");

  property p_read_acc;
    I_RD && I_ADDR == `ACC_OFFSET |=> O_RDATA == $past(acc_r);
  endproperty
  a_read_acc: assert property (p_read_acc)
    else $error("read of operand register returned wrong value");

  c_add_carry: cover property (
    I_OP == cpu_flags_pkg::OP_ADD && chk_sum9[8]);
  c_div_zero: cover property (
    I_OP == cpu_flags_pkg::OP_DIV && I_OPERAND == 8'h00);
  c_bank_three: cover property (bank == 2'b11 ##1 O_REG_ADDR[4:3] == 2'b11);
  c_bit_write: cover property (
    I_BIT_WR && (I_ADDR & `BIT_REG_MASK) == `PSW_OFFSET);
  c_clear_race: cover property (
    I_WR && I_ADDR == `PSW_OFFSET && I_OP == cpu_flags_pkg::OP_ADD);

endmodule

// file: verilog/flag_alu.sv
`timescale 1ns/1ps

module flag_alu (
  // operation
  input  wire cpu_flags_pkg::alu_op_e i_op,
  input  wire logic [7:0]             i_a,
  input  wire logic [7:0]             i_b,
  input  wire logic                   i_cin,
  // results
  output logic [7:0]                  o_res,
  output logic [7:0]                  o_hi,
  output logic                        o_carry,
  output logic                        o_half,
  output logic                        o_ovfl,
  // which results are to be taken
  output logic                        o_wr_res,
  output logic                        o_wr_hi,
  output logic                        o_upd_carry,
  output logic                        o_upd_half,
  output logic                        o_upd_ovfl
);

  logic [8:0]  wide9;
  logic [4:0]  nib5;
  logic [15:0] prod16;
  logic        c;

  always_comb begin
    o_res    = i_a;
    o_hi        = 8'h00;
    o_carry     = 1'b0;
    o_half      = 1'b0;
    o_ovfl      = 1'b0;
    o_wr_res    = 1'b0;
    o_wr_hi     = 1'b0;
    o_upd_carry = 1'b0;
    o_upd_half  = 1'b0;
    o_upd_ovfl  = 1'b0;
    c        = (i_op == cpu_flags_pkg::OP_NOP ||
                i_op == cpu_flags_pkg::OP_ADD) ? 1'b0 : i_cin;
    wide9    = 9'h000;
    nib5     = 5'h00;
    prod16   = {8'h00, i_a} * {8'h00, i_b};
    case (i_op)
      cpu_flags_pkg::OP_ADD, cpu_flags_pkg::OP_ADDC: begin
        wide9       = {1'b0, i_a} + {1'b0, i_b} + {8'h00, c};
        nib5        = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, c};
        o_res       = wide9[7:0];
        o_carry     = wide9[8];
        o_half      = nib5[4];
        o_ovfl      = (i_a[7] == i_b[7]) && (wide9[7] != i_a[7]);
        o_wr_res    = 1'b1;
        o_upd_carry = 1'b1;
        o_upd_half  = 1'b1;
        o_upd_ovfl  = 1'b1;
      end
      cpu_flags_pkg::OP_SUBB: begin
        // a borrow wraps the difference, leaving the top bit set
        wide9       = {1'b0, i_a} - {1'b0, i_b} - {8'h00, c};
        nib5        = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]} - {4'h0, c};
        o_res       = wide9[7:0];
        o_carry     = wide9[8];
        o_half      = nib5[4];
        o_ovfl      = (i_a[7] != i_b[7]) && (wide9[7] != i_a[7]);
        o_wr_res    = 1'b1;
        o_upd_carry = 1'b1;
        o_upd_half  = 1'b1;
        o_upd_ovfl  = 1'b1;
      end
      cpu_flags_pkg::OP_MUL: begin
        o_res       = prod16[7:0];
        o_hi        = prod16[15:8];
        o_ovfl      = |prod16[15:8];
        o_wr_res    = 1'b1;
        o_wr_hi     = 1'b1;
        o_upd_carry = 1'b1;
        o_upd_ovfl  = 1'b1;
      end
      cpu_flags_pkg::OP_DIV: begin
        // a zero divisor leaves the operand untouched
        if (i_b == 8'h00) begin
          o_ovfl = 1'b1;
        end else begin
          o_res    = i_a / i_b;
          o_hi     = i_a % i_b;
          o_wr_res = 1'b1;
          o_wr_hi  = 1'b1;
        end
        o_upd_carry = 1'b1;
        o_upd_ovfl  = 1'b1;
      end
      default: begin
        o_res = i_a;
      end
    endcase
  end

endmodule
